// ---- hw/line_section_enable_regs.svh ----
`ifndef LINE_SECTION_ENABLE_REGS_SVH
`define LINE_SECTION_ENABLE_REGS_SVH
// Register offsets on the parallel port
`define RX_ENABLE_LO_OFFSET 8'h08
`define TX_ENABLE_HI_OFFSET 8'h80
// Field layout: six enable bits at the bottom
`define ENABLE_FIELD_LSB 0
`define ENABLE_FIELD_MSB 5
// Reset values: all sections off
`define RX_ENABLE_LO_RESET 6'h00
`define TX_ENABLE_HI_RESET 6'h00
// Pin input filter depth in cycles
`define SYNC_STAGES 3
`endif

// ---- hw/line_section_pkg.sv ----
package line_section_pkg;
   typedef logic [5:0] enable_field_t;
   typedef logic [7:0] reg_byte_t;
endpackage

// ---- hw/enable_bit_sync.sv ----
`timescale 1ns/1ps
`include "line_section_enable_regs.svh"
// Three-stage filter for a pin: accept change when stages two and three agree
module enable_bit_sync
(
   input wire logic clk,   // System clock
   input wire logic nrst,  // Async reset, active low
   input wire logic din,   // Raw pin level
   output logic dout       // Filtered level
);
   logic [`SYNC_STAGES-1:0] stage_r;
   logic [`SYNC_STAGES-1:0] stage_nxt;
   logic dout_r;
   logic dout_nxt;

   // Shift chain and agreement test on the last two stages
   always_comb
   begin
      stage_nxt = {stage_r[`SYNC_STAGES-2:0], din};
      dout_nxt = dout_r;
      if (stage_r[1] == stage_r[2])
      begin
         dout_nxt = stage_r[2];
      end
   end

   // Registers
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stage_r <= '0;
         dout_r <= 1'b0;
      end
      else
      begin
         stage_r <= stage_nxt;
         dout_r <= dout_nxt;
      end
   end

   assign dout = dout_r;
endmodule

// ---- hw/line_section_enable_regs.sv ----
`timescale 1ns/1ps
`include "line_section_enable_regs.svh"
// Behaviour
// - Register 0x08 enables receivers channels 0-5
// - Each receive bit controls only its channel
// - Receive bit 0: receiver off, inputs hi-Z
// - Receive bit 1: receiver powered, accepts pulses
// - Register 0x80 enables drivers channels 6-11
// - Transmit bit 0: driver off, outputs tri-stated
// - Transmit bit 1 and permitted: drive pulses
// - Master enable pin low tri-states every driver
module line_section_enable_regs
(
   input wire logic SYS_CLK,                    // 125 MHz clock
   input wire logic NRST,                       // Async reset, active low
   input wire logic [7:0] ADDR,                 // Register address
   input wire logic [7:0] WDATA,                // Write data
   input wire logic WR_EN,                      // Write strobe, one cycle
   input wire logic RD_EN,                      // Read strobe, one cycle
   output logic [7:0] RDATA,                    // Read data, registered
   output logic RDATA_VALID,                    // Read data valid pulse
   input wire logic TRANSMIT_MASTER_ON,         // Master transmit enable pin
   input wire logic [5:0] LINE_INPUT_POSITIVE,  // Rx positive inputs ch0-5
   input wire logic [5:0] LINE_INPUT_NEGATIVE,  // Rx negative inputs ch0-5
   output logic [5:0] RX_LINE_INPUT_OE,         // Input termination active ch0-5
   output logic [5:0] RX_DATA_POSITIVE,         // Accepted positive pulses
   output logic [5:0] RX_DATA_NEGATIVE,         // Accepted negative pulses
   output logic [5:0] RECEIVE_SECTION_ON,       // Receiver power ch0-5
   input wire logic [5:0] TX_DATA_POSITIVE,     // Positive pulses ch6-11
   input wire logic [5:0] TX_DATA_NEGATIVE,     // Negative pulses ch6-11
   output logic [5:0] LINE_OUTPUT_POSITIVE,     // Tx positive outputs ch6-11
   output logic [5:0] LINE_OUTPUT_NEGATIVE,     // Tx negative outputs ch6-11
   output logic [5:0] LINE_OUTPUT_OE,           // Driver enable ch6-11
   output logic [5:0] TRANSMIT_SECTION_ON       // Driver power ch6-11
);
   line_section_pkg::enable_field_t rx_en_r;
   line_section_pkg::enable_field_t rx_en_nxt;
   line_section_pkg::enable_field_t tx_en_r;
   line_section_pkg::enable_field_t tx_en_nxt;
   line_section_pkg::reg_byte_t rdata_r;
   line_section_pkg::reg_byte_t rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [5:0] rxp_r;
   logic [5:0] rxp_nxt;
   logic [5:0] rxn_r;
   logic [5:0] rxn_nxt;
   logic [5:0] txp_r;
   logic [5:0] txp_nxt;
   logic [5:0] txn_r;
   logic [5:0] txn_nxt;
   logic [5:0] tx_active;
   logic master_on;
   logic [5:0] lip_sync;
   logic [5:0] lin_sync;

   // Address match shared by write and read decode
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
      addr_hit = (a == off);
   endfunction

   // Pad an enable field to a bus byte; reserved bits read zero
   function automatic line_section_pkg::reg_byte_t reg_byte
   (
      input line_section_pkg::enable_field_t f
   );
      reg_byte = {2'h0, f};
   endfunction

   // Master pin from outside the clock domain
   enable_bit_sync u_master_sync
   (
      .clk(SYS_CLK),
      .nrst(NRST),
      .din(TRANSMIT_MASTER_ON),
      .dout(master_on)
   );

   // Line pins are asynchronous too: one agreement filter per pin
   genvar ch;
   generate
      for (ch = 0; ch < 6; ch = ch + 1)
      begin : g_line_in
         enable_bit_sync u_pos_sync
         (
            .clk(SYS_CLK),
            .nrst(NRST),
            .din(LINE_INPUT_POSITIVE[ch]),
            .dout(lip_sync[ch])
         );
         enable_bit_sync u_neg_sync
         (
            .clk(SYS_CLK),
            .nrst(NRST),
            .din(LINE_INPUT_NEGATIVE[ch]),
            .dout(lin_sync[ch])
         );
      end
   endgenerate

   // Enable register writes; reserved bits never stored
   always_comb
   begin
      rx_en_nxt = rx_en_r;
      tx_en_nxt = tx_en_r;
      if (WR_EN && addr_hit(ADDR, `RX_ENABLE_LO_OFFSET))
      begin
         rx_en_nxt = WDATA[`ENABLE_FIELD_MSB:`ENABLE_FIELD_LSB];
      end
      if (WR_EN && addr_hit(ADDR, `TX_ENABLE_HI_OFFSET))
      begin
         tx_en_nxt = WDATA[`ENABLE_FIELD_MSB:`ENABLE_FIELD_LSB];
      end
   end

   // Enable registers, all sections off after reset
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rx_en_r <= `RX_ENABLE_LO_RESET;
         tx_en_r <= `TX_ENABLE_HI_RESET;
      end
      else
      begin
         rx_en_r <= rx_en_nxt;
         tx_en_r <= tx_en_nxt;
      end
   end

   // Read mux; a write in the same cycle shows only on the next read
   always_comb
   begin
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      if (RD_EN)
      begin
         rvalid_nxt = 1'b1;
         if (addr_hit(ADDR, `RX_ENABLE_LO_OFFSET))
         begin
            rdata_nxt = reg_byte(rx_en_r);
         end
         else if (addr_hit(ADDR, `TX_ENABLE_HI_OFFSET))
         begin
            rdata_nxt = reg_byte(tx_en_r);
         end
         else
         begin
            rdata_nxt = 8'h00;
         end
      end
   end

   // Read data holds until the next read; valid is a one-cycle pulse
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // Driver permitted only with bit set and master pin high
   assign tx_active = tx_en_r & {6{master_on}};

   // Per-channel line gating, receive side on filtered pins; off channels pass nothing
   always_comb
   begin
      rxp_nxt = lip_sync & rx_en_r;
      rxn_nxt = lin_sync & rx_en_r;
      txp_nxt = TX_DATA_POSITIVE & tx_active;
      txn_nxt = TX_DATA_NEGATIVE & tx_active;
   end

   // Line data registers
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rxp_r <= 6'h00;
         rxn_r <= 6'h00;
         txp_r <= 6'h00;
         txn_r <= 6'h00;
      end
      else
      begin
         rxp_r <= rxp_nxt;
         rxn_r <= rxn_nxt;
         txp_r <= txp_nxt;
         txn_r <= txn_nxt;
      end
   end

   // Register read port
   assign RDATA = rdata_r;
   assign RDATA_VALID = rvalid_r;

   // Receive side: power and input termination follow the enable bits
   assign RECEIVE_SECTION_ON = rx_en_r;
   assign RX_LINE_INPUT_OE = rx_en_r;
   assign RX_DATA_POSITIVE = rxp_r;
   assign RX_DATA_NEGATIVE = rxn_r;

   // Transmit side: driver power and enable follow the gated bits
   assign TRANSMIT_SECTION_ON = tx_active;
   assign LINE_OUTPUT_OE = tx_active;
   assign LINE_OUTPUT_POSITIVE = txp_r;
   assign LINE_OUTPUT_NEGATIVE = txn_r;
endmodule

// ---- verification/enable_regs_chk.sv ----
`timescale 1ns/1ps
module enable_regs_chk
(
   input wire logic SYS_CLK, // Clock
   input wire logic NRST, // Async reset, active low
   input wire logic WR_EN, // Write strobe
   input wire logic RD_EN, // Read strobe
   input wire logic RDATA_VALID, // Read valid pulse
   input wire logic TRANSMIT_MASTER_ON, // Master pin
   input wire logic [7:0] ADDR, // Address
   input wire logic [7:0] WDATA, // Write data
   input wire logic [7:0] RDATA, // Read data
   input wire logic [5:0] RECEIVE_SECTION_ON, // Receiver power
   input wire logic [5:0] RX_LINE_INPUT_OE, // Receiver inputs active
   input wire logic [5:0] LINE_OUTPUT_OE, // Driver enable
   input wire logic [5:0] TRANSMIT_SECTION_ON // Driver power
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   // Master pin held low long enough to pass the filter
   sequence s_master_off;
      !TRANSMIT_MASTER_ON [*7];
   endsequence
   a_rd_valid_pulse: assert property (RD_EN |=> RDATA_VALID)
      else $error("no valid");
   a_valid_no_read: assert property (!RD_EN |=> !RDATA_VALID)
      else $error("stray valid");
   a_rsvd_read_zero: assert property (RDATA_VALID |-> RDATA[7:6] == 2'h0)
      else $error("reserved bits set");
   a_unmapped_read: assert property (RD_EN && ADDR != 8'h08 && ADDR != 8'h80
      |=> RDATA == 8'h00) else $error("unmapped read");
   a_rx_write_take: assert property (WR_EN && ADDR == 8'h08 |=>
      RECEIVE_SECTION_ON == 6'($past(WDATA))) else $error("rx write lost");
   a_rx_hold_still: assert property (!(WR_EN && ADDR == 8'h08)
      |=> $stable(RECEIVE_SECTION_ON)) else $error("rx changed");
   a_rx_pins_follow: assert property (RX_LINE_INPUT_OE == RECEIVE_SECTION_ON)
      else $error("rx pins");
   a_tx_master_off: assert property (s_master_off |-> LINE_OUTPUT_OE == 6'h00)
      else $error("driver on");
   a_tx_oe_pair: assert property (LINE_OUTPUT_OE == TRANSMIT_SECTION_ON)
      else $error("driver pair");
endmodule
bind line_section_enable_regs enable_regs_chk u_chk(.SYS_CLK(SYS_CLK), .NRST(NRST),
   .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA_VALID(RDATA_VALID), .ADDR(ADDR), .WDATA(WDATA),
   .TRANSMIT_MASTER_ON(TRANSMIT_MASTER_ON), .RDATA(RDATA), .LINE_OUTPUT_OE(LINE_OUTPUT_OE),
   .RECEIVE_SECTION_ON(RECEIVE_SECTION_ON), .RX_LINE_INPUT_OE(RX_LINE_INPUT_OE),
   .TRANSMIT_SECTION_ON(TRANSMIT_SECTION_ON));

// ---- verification/host_port.sv ----
`timescale 1ns/1ps
module host_port
(
   input wire logic clk, // Clock
   input wire logic rv, // Read valid
   input wire logic [7:0] rdata, // Read data
   output logic [7:0] a = 0, // Address
   output logic [7:0] d = 0, // Write data
   output logic w = 0, // Write strobe
   output logic r = 0 // Read strobe
);
   // One-cycle strobe; released bus shows inverted last value
   task automatic xfer(input logic wr, input logic [7:0] ad, dt, output logic [8:0] q);
      @(negedge clk);
      a = ad;
      d = dt;
      w = wr;
      r = !wr;
      @(negedge clk);
      q = {rv, rdata};
      w = 0;
      r = 0;
      a = ~a;
      d = ~d;
   endtask
endmodule

// ---- verification/line_section_enable_regs_tb.sv ----
`timescale 1ns/1ps
module line_section_enable_regs_tb;
   logic clk = 0, nrst = 0, mst = 0;
   logic [5:0] lp = 0, tp = 0;
   logic [7:0] ra, ad, wd;
   logic [8:0] q;
   wire logic [7:0] rd;
   wire logic w, r, rv;
   wire logic [5:0] rxo, rxp, rxn, receive_section_on, lop, lon, loe, transmit_section_on;
   int failures = 0, checked = 0, seed = 32'he4f1, cyc = 0, rx_m = 0, tx_m = 0, g, e;
   always #4 clk = ~clk;
   host_port u_host(.clk(clk), .rv(rv), .rdata(rd), .a(ad), .d(wd), .w(w), .r(r));
   line_section_enable_regs u_dut(.SYS_CLK(clk), .NRST(nrst), .ADDR(ad), .WDATA(wd),
      .WR_EN(w), .RD_EN(r), .RDATA(rd), .RDATA_VALID(rv), .TRANSMIT_MASTER_ON(mst),
      .LINE_INPUT_POSITIVE(lp), .LINE_INPUT_NEGATIVE(~lp), .RX_LINE_INPUT_OE(rxo),
      .RX_DATA_POSITIVE(rxp), .RX_DATA_NEGATIVE(rxn), .RECEIVE_SECTION_ON(receive_section_on),
      .TX_DATA_POSITIVE(tp), .TX_DATA_NEGATIVE(~tp), .LINE_OUTPUT_POSITIVE(lop),
      .LINE_OUTPUT_NEGATIVE(lon), .LINE_OUTPUT_OE(loe), .TRANSMIT_SECTION_ON(transmit_section_on));
   // Compare and count
   task chk(input string n, input logic [23:0] x, v);
      checked++;
      if (x !== v)
      begin
         failures++;
         $display("Error %s exp %h got %h", n, x, v);
      end
   endtask
   // Verdict
   task results;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Cycle ceiling against a hang
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         failures++;
         results;
      end
   end
   // Random writes, read-back and pin effects
   initial
   begin
      repeat (10) @(posedge clk);
      @(negedge clk) nrst = 1;
      repeat (40)
      begin
         e = $random(seed);
         ra = e[1] ? (e[0] ? 8'h80 : 8'h08) : e[15:8];
         u_host.xfer(1, ra, e[31:24], q);
         if (ra == 8'h08) rx_m = e[29:24];
         if (ra == 8'h80) tx_m = e[29:24];
         u_host.xfer(0, ra, e[23:16], q);
         mst = e[2];
         e = 256 | (ra == 8'h08 ? rx_m : ra == 8'h80 ? tx_m : 0);
         chk("read", 24'(e), 24'(q));
         lp = 6'($random(seed));
         tp = 6'($random(seed));
         g = mst ? tx_m : 0;
         repeat (8) @(negedge clk);
         e = rx_m << 18 | rx_m << 12 | g << 6 | g;
         chk("enables", 24'(e), {receive_section_on, rxo, transmit_section_on, loe});
         e = (lp & rx_m) << 18 | (~lp & rx_m) << 12 | (tp & g) << 6 | ~tp & g;
         chk("data", 24'(e), {rxp, rxn, lop, lon});
      end
      $display("random enable test done");
      // Reset in mid-run: every section off, both registers read zero
      @(negedge clk) nrst = 0;
      repeat (2) @(negedge clk);
      nrst = 1;
      rx_m = 0;
      tx_m = 0;
      u_host.xfer(0, 8'h08, 8'h00, q);
      chk("rx after reset", 24'h00_0100, 24'(q));
      u_host.xfer(0, 8'h80, 8'h00, q);
      chk("tx after reset", 24'h00_0100, 24'(q));
      chk("enables after reset", 24'h00_0000, {receive_section_on, rxo, transmit_section_on, loe});
      $display("mid-run reset test done");
      results;
   end
endmodule
